// ### src/lsd_device.sv
// Display end: serial frame decoder, display timing and key scan
`timescale 1ns/1ps
`default_nettype none
`include "lsd_defines.svh"
module lsd_device
    import lsd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Device pins
    input wire logic hw_reset_n_i,
    input wire logic [4:0] scan_sense_lines_i,
    output logic [44:0] seg_o,
    output logic [3:0] port_mode_o,
    output logic backplane_phase_a_o,
    output logic backplane_phase_b_o,
    output logic [5:0] scan_drive_lines_o,
    output logic [29:0] key_data_o,
    output logic sleep_o,
    output logic osc_run_o,
    // Link
    lsd_link_if.dev link
);
    import lsd_pkg::*;
    localparam logic [11:0] OSC_CYC = 12'(`LSD_OSC_CYC - 1);
    localparam int FDIV_W = $clog2(`LSD_FRAME_DIV);

    // Two-stage synchronisers for pins from outside the clock domain
    logic [1:0] ce_s_r;
    logic [1:0] sck_s_r;
    logic [1:0] din_s_r;
    logic [1:0] rst_s_r;
    logic [4:0] sense_s0_r;
    logic [4:0] sense_s1_r;
    logic ce_d_r;
    logic sck_d_r;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ce_s_r <= '0;
            sck_s_r <= '0;
            din_s_r <= '0;
            // Pin idles high; a low start would fake a hardware reset
            rst_s_r <= 2'b11;
            sense_s0_r <= '0;
            sense_s1_r <= '0;
            ce_d_r <= 1'b0;
            sck_d_r <= 1'b0;
        end else begin
            ce_s_r <= {ce_s_r[0], link.ce};
            sck_s_r <= {sck_s_r[0], link.shift_clk};
            din_s_r <= {din_s_r[0], link.serial_in};
            rst_s_r <= {rst_s_r[0], hw_reset_n_i};
            sense_s0_r <= scan_sense_lines_i;
            sense_s1_r <= sense_s0_r;
            ce_d_r <= ce_s_r[1];
            sck_d_r <= sck_s_r[1];
        end
    end
    wire ce = ce_s_r[1]; // R11
    wire sck_rise = sck_s_r[1] && !sck_d_r;
    wire ce_rise = ce && !ce_d_r;
    wire ce_fall = !ce && ce_d_r;
    wire hw_rst = !rst_s_r[1];

    // Serial receiver; runs through hardware reset so data still lands
    logic [7:0] addr_r;
    logic sel_r;
    logic [6:0] cnt_r;
    lsd_frame_t pay_r;
    lsd_frame_t cfg_r;
    wire full = cnt_r == `LSD_FRAME_BITS;
    wire apply = ce_fall && sel_r && full; // R22
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            addr_r <= '0;
            sel_r <= 1'b0;
            cnt_r <= '0;
            pay_r <= '0;
        end else begin
            if (sck_rise && !ce) begin
                addr_r <= {din_s_r[1], addr_r[7:1]};
            end
            if (ce_rise) begin
                sel_r <= addr_r == `LSD_ADDR; // R01
                cnt_r <= '0;
            end else if (sck_rise && ce && sel_r && !full) begin
                pay_r <= {din_s_r[1], pay_r[96:1]}; // R22
                cnt_r <= cnt_r + 1'b1;
            end
            if (ce_fall) begin
                sel_r <= 1'b0;
            end
        end
    end
    // Pixel bits and control fields held until the next good frame
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cfg_r <= '0;
        end else if (apply) begin
            cfg_r <= pay_r; // R02 R03
        end
    end
    wire [89:0] pixel_bits = cfg_r[`LSD_PIX_BITS-1:0];
    wire sleep_sel_lo = cfg_r[`LSD_BIT_SLEEP_LO];
    wire sleep_sel_hi = cfg_r[`LSD_BIT_SLEEP_HI];
    wire scanpin_share_a = cfg_r[`LSD_BIT_SHARE_A];
    wire scanpin_share_b = cfg_r[`LSD_BIT_SHARE_B];
    wire port_sel_a = cfg_r[`LSD_BIT_PORT_A];
    wire port_sel_b = cfg_r[`LSD_BIT_PORT_B];
    wire segment_blank = cfg_r[`LSD_BIT_BLANK];
    wire sleep = sleep_sel_lo || sleep_sel_hi; // R04 R05

    // Key scan state
    lsd_key_st_t ks_r;
    logic [2:0] line_r;
    logic [3:0] step_r;
    logic [29:0] key_r;
    logic [29:0] acc_r;
    logic req_r;
    wire any_key = |sense_s1_r; // R14
    wire scanning = ks_r == KS_SCAN;

    // Oscillator restarts in sleep only for a key scan
    wire osc_run = !sleep || scanning || any_key; // R05
    logic [11:0] osc_cnt_r;
    logic [FDIV_W-1:0] fdiv_r;
    wire osc_tick = osc_run && (osc_cnt_r == OSC_CYC);
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            osc_cnt_r <= '0;
            fdiv_r <= '0;
        end else if (osc_run) begin
            osc_cnt_r <= osc_tick ? '0 : osc_cnt_r + 1'b1;
            if (osc_tick) begin
                fdiv_r <= fdiv_r + 1'b1; // R08
            end
        end
    end
    // One frame is two backplane phases of 256 oscillator periods each
    wire phase_b = fdiv_r[FDIV_W-1]; // R16

    // Pin sharing decode
    wire first_seg = scanpin_share_a || scanpin_share_b; // R18
    wire second_seg = scanpin_share_a; // R18
    // Shared pins are forced to scan while asleep or scanning
    wire stby = sleep || scanning;
    wire pin1_seg = first_seg && !stby; // R07 R10
    wire pin2_seg = second_seg && !stby; // R07 R10
    wire [3:0] port_en = {port_sel_a && port_sel_b, port_sel_a,
        port_sel_a || port_sel_b, port_sel_a || port_sel_b}; // R19

    // Scan line levels
    logic [5:0] stby_lvl;
    always_comb begin
        unique case ({sleep_sel_lo, sleep_sel_hi})
            2'b00: stby_lvl = `LSD_STBY_ALL; // R04
            2'b01: stby_lvl = `LSD_STBY_01; // R06
            2'b10: stby_lvl = `LSD_STBY_10; // R06
            2'b11: stby_lvl = `LSD_STBY_ALL; // R06
        endcase
    end
    wire [5:0] scan_lvl = scanning ? 6'(1 << line_r) : stby_lvl;

    // Segment levels, one generate per pin
    logic [44:0] seg_nxt;
    wire seg_off = sleep || segment_blank || hw_rst; // R05 R13 R20
    genvar gi;
    generate
        for (gi = 0; gi < `LSD_SEGS; gi++) begin : g_seg
            // Pixel bit 2n-1 on phase a, 2n on phase b
            wire lvl = phase_b ? pixel_bits[2*gi+1] : pixel_bits[2*gi];
            if (gi < 4) begin : g_port
                assign seg_nxt[gi] = port_en[gi] ? pixel_bits[2*gi] :
                    (lvl && !seg_off); // R09 R19 R21
            end else if (gi == 43) begin : g_sh1
                assign seg_nxt[gi] = pin1_seg ? (lvl && !seg_off) :
                    scan_lvl[0]; // R10
            end else if (gi == 44) begin : g_sh2
                assign seg_nxt[gi] = pin2_seg ? (lvl && !seg_off) :
                    scan_lvl[1]; // R10
            end else begin : g_plain
                assign seg_nxt[gi] = lvl && !seg_off; // R17 R21
            end
        end
    endgenerate
    wire [5:0] scan_nxt = {scan_lvl[5:2], seg_nxt[44:43]};

    // Key scan: idle until a sense line goes high, then walk lines
    wire step_end = osc_tick && (step_r == `LSD_SCAN_STEP - 4'd1);
    wire last_line = line_r == `LSD_SCAN_LINES - 3'd1;
    // Lines lent to segment drive return to scan while scanning and report keys
    wire line_off = (line_r == 3'd0 && pin1_seg) ||
        (line_r == 3'd1 && pin2_seg);
    wire [29:0] acc_nxt = acc_r |
        (line_off ? 30'h0 : (30'(sense_s1_r) << (5'(line_r) * 5'h05)));
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || hw_rst) begin
            ks_r <= KS_IDLE;
            line_r <= '0;
            step_r <= '0;
            acc_r <= '0;
            key_r <= '0; // R13
            req_r <= 1'b0;
        end else begin
            unique case (ks_r)
                KS_IDLE: begin
                    if (any_key) begin
                        ks_r <= KS_SCAN; // R15
                        line_r <= '0;
                        step_r <= '0;
                        acc_r <= '0;
                    end
                end
                KS_SCAN: begin
                    if (osc_tick) begin
                        step_r <= step_r + 1'b1;
                    end
                    if (step_end) begin
                        step_r <= '0;
                        acc_r <= acc_nxt;
                        line_r <= last_line ? '0 : line_r + 1'b1;
                        if (last_line) begin
                            key_r <= acc_nxt;
                            req_r <= acc_nxt != '0;
                            acc_r <= '0;
                            if (acc_nxt == '0) begin
                                ks_r <= KS_IDLE; // R15
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Registered pin outputs
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            seg_o <= '0;
            scan_drive_lines_o <= '0;
            backplane_phase_a_o <= 1'b0;
            backplane_phase_b_o <= 1'b0;
            port_mode_o <= '0;
        end else begin
            seg_o <= seg_nxt;
            scan_drive_lines_o <= scan_nxt;
            backplane_phase_a_o <= !sleep && !phase_b; // R05 R16
            backplane_phase_b_o <= !sleep && phase_b; // R05 R16
            port_mode_o <= port_en;
        end
    end
    assign key_data_o = key_r;
    assign sleep_o = sleep;
    assign osc_run_o = osc_run;
    // Only ever pulls low; released while a frame is being sent
    assign link.dout_o = 1'b0; // R12
    assign link.dout_oe = req_r && !ce; // R12
endmodule
`default_nettype wire

// ### src/lsd_defines.svh
// Constants for the serial-framed segment display decoder and its host
// Behaviour
// R01 - Frames addressed 42H are the only ones taken
// R02 - Ninety pixel bits stored as segment pattern
// R03 - Payload also carries sleep, share, port, blank fields
// R04 - Sleep field 00: normal, scan lines high
// R05 - Nonzero sleep: oscillator stops, segments, commons low
// R06 - Sleep scan standby levels follow sleep field
// R07 - Shared pins are scan outputs in standby
// R08 - Frame rate is oscillator divided by 512
// R09 - First four segment pins become ports
// R10 - First two scan pins become segment pins
// R11 - Link: chip enable high, shift clock, data
// R12 - Data out only pulls low, line pulled up
// R13 - Reset blanks segments, clears keys, keeps serial
// R14 - Unpressed sense line reads zero
// R15 - Key scan runs only after a press
// R16 - Half duty, two backplane phases, ninety segments
// R17 - Pixel bits drive segments without decoding
// R18 - Share field: 00 scan, 01 first, 1x both
// R19 - Port field selects ports; port shows odd bit
// R20 - Blank bit 1 turns all segments off
// R21 - Segment n shows bits 2n-1 then 2n
// R22 - Bits shifted in, fields applied at frame end
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH
`define LSD_ADDR 8'h42
`define LSD_ADDR_BITS 4'd8
`define LSD_FRAME_BITS 7'd97
`define LSD_PIX_BITS 90
`define LSD_SEGS 45
`define LSD_BIT_SLEEP_LO 90
`define LSD_BIT_SLEEP_HI 91
`define LSD_BIT_SHARE_A 92
`define LSD_BIT_SHARE_B 93
`define LSD_BIT_PORT_A 94
`define LSD_BIT_PORT_B 95
`define LSD_BIT_BLANK 96
`define LSD_CLK_MHZ 200
`define LSD_PULSE_NS 160
`define LSD_HALF_CYC ((`LSD_PULSE_NS * `LSD_CLK_MHZ + 999) / 1000)
`define LSD_OSC_KHZ 50
`define LSD_OSC_CYC ((`LSD_CLK_MHZ * 1000) / `LSD_OSC_KHZ)
`define LSD_FRAME_DIV 512
`define LSD_SCAN_STEP 4'd8
`define LSD_SCAN_LINES 3'd6
`define LSD_STBY_01 6'h20
`define LSD_STBY_10 6'h30
`define LSD_STBY_ALL 6'h3f
`endif

// ### src/lsd_pkg.sv
// Shared types for the segment display link
package lsd_pkg;
    typedef logic [96:0] lsd_frame_t;
    typedef enum logic [2:0] {
        HS_IDLE, HS_ADDR, HS_CEUP, HS_DATA, HS_CEDN
    } lsd_host_st_t;
    typedef enum logic {KS_IDLE, KS_SCAN} lsd_key_st_t;
endpackage

// ### src/lsd_link_if.sv
// Serial link between controller and display decoder
`timescale 1ns/1ps
`default_nettype none
interface lsd_link_if;
    logic ce;
    logic shift_clk;
    logic serial_in;
    logic dout_o;
    logic dout_oe;
    logic dout_line;
    // Open-drain with external pull-up
    assign dout_line = dout_oe ? dout_o : 1'b1;
    modport host (
        output ce,
        output shift_clk,
        output serial_in,
        input dout_line
    );
    modport dev (
        input ce,
        input shift_clk,
        input serial_in,
        output dout_o,
        output dout_oe
    );
endinterface
`default_nettype wire

// ### src/lsd_host.sv
// Controller end: frame FIFO and serial frame sender
`timescale 1ns/1ps
`default_nettype none
`include "lsd_defines.svh"
module lsd_fifo #(
    parameter int W = 97,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D + 1);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = cnt_r != CW'(D);
    assign out_valid_o = cnt_r != '0;
    assign out_data_o = mem_r[rp_r];
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + CW'(push) - CW'(pop);
        end
    end
endmodule

module lsd_host
    import lsd_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Frame requests: pixel bits 0..89 then control bits
    input wire logic frame_valid_i,
    output logic frame_ready_o,
    input wire lsd_pkg::lsd_frame_t frame_i,
    output logic busy_o,
    output logic key_req_o,
    // Link
    lsd_link_if.host link
);
    import lsd_pkg::*;
    localparam logic [5:0] HALF = 6'(`LSD_HALF_CYC);
    localparam logic [7:0] ADDR = `LSD_ADDR;
    lsd_host_st_t st_r;
    lsd_frame_t sh_r;
    lsd_frame_t fifo_data;
    logic fifo_valid;
    logic [5:0] tmr_r;
    logic [6:0] bit_r;
    logic [7:0] addr_r;
    logic ce_r;
    logic sck_r;
    logic sdo_r;
    logic [1:0] req_sync_r;
    wire tmr_done = tmr_r == '0;
    wire take = (st_r == HS_IDLE) && fifo_valid;
    lsd_fifo #(.W(97), .D(8)) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(frame_valid_i),
        .in_ready_o(frame_ready_o),
        .in_data_i(frame_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(take),
        .out_data_o(fifo_data)
    );
    assign link.ce = ce_r; // R11
    assign link.shift_clk = sck_r;
    assign link.serial_in = sdo_r;
    assign busy_o = st_r != HS_IDLE;
    // Pulled-up line reads low while the device asks for a key read
    assign key_req_o = ~req_sync_r[1]; // R12
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            req_sync_r <= 2'b11;
        end else begin
            req_sync_r <= {req_sync_r[0], link.dout_line};
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            st_r <= HS_IDLE;
            sh_r <= '0;
            tmr_r <= '0;
            bit_r <= '0;
            addr_r <= '0;
            ce_r <= 1'b0;
            sck_r <= 1'b0;
            sdo_r <= 1'b0;
        end else begin
            tmr_r <= tmr_done ? '0 : tmr_r - 1'b1;
            unique case (st_r)
                HS_IDLE: begin
                    if (take) begin
                        sh_r <= fifo_data;
                        addr_r <= ADDR >> 1; // R01
                        sdo_r <= ADDR[0];
                        bit_r <= '0;
                        tmr_r <= HALF;
                        st_r <= HS_ADDR;
                    end
                end
                HS_ADDR: begin
                    if (tmr_done && !sck_r) begin
                        sck_r <= 1'b1;
                        tmr_r <= HALF;
                    end else if (tmr_done) begin
                        sck_r <= 1'b0;
                        tmr_r <= HALF;
                        if (bit_r == 7'(`LSD_ADDR_BITS - 1)) begin
                            st_r <= HS_CEUP;
                        end else begin
                            sdo_r <= addr_r[0];
                            addr_r <= {1'b0, addr_r[7:1]};
                            bit_r <= bit_r + 1'b1;
                        end
                    end
                end
                HS_CEUP: begin
                    if (tmr_done) begin
                        ce_r <= 1'b1;
                        sdo_r <= sh_r[0]; // R22
                        sh_r <= {1'b0, sh_r[96:1]};
                        bit_r <= '0;
                        tmr_r <= HALF;
                        st_r <= HS_DATA;
                    end
                end
                HS_DATA: begin
                    if (tmr_done && !sck_r) begin
                        sck_r <= 1'b1;
                        tmr_r <= HALF;
                    end else if (tmr_done) begin
                        sck_r <= 1'b0;
                        tmr_r <= HALF;
                        if (bit_r == `LSD_FRAME_BITS - 7'd1) begin
                            st_r <= HS_CEDN;
                        end else begin
                            sdo_r <= sh_r[0];
                            sh_r <= {1'b0, sh_r[96:1]};
                            bit_r <= bit_r + 1'b1;
                        end
                    end
                end
                HS_CEDN: begin
                    if (tmr_done) begin
                        ce_r <= 1'b0;
                        tmr_r <= HALF;
                        st_r <= HS_IDLE;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### tb/lsd_link_properties.sv
// Protocol checks on the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none
module lsd_link_properties (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Link signals
    input wire logic ce,
    input wire logic shift_clk,
    input wire logic serial_in,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic dout_line
);
    logic sclk_q_r;
    logic ce_q_r;
    logic [5:0] lvl_cnt_r;
    logic [7:0] addr_sh_r;
    logic [6:0] bit_cnt_r;
    wire logic sclk_edge = shift_clk != sclk_q_r;
    wire logic sclk_rise = shift_clk && !sclk_q_r;

    // Level counter saturates so long idle gaps never wrap to a short one
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sclk_q_r <= 1'b0;
            ce_q_r <= 1'b0;
            lvl_cnt_r <= 6'h00;
            addr_sh_r <= 8'h00;
            bit_cnt_r <= 7'h00;
        end else begin
            sclk_q_r <= shift_clk;
            ce_q_r <= ce;
            if (sclk_edge)
                lvl_cnt_r <= 6'h00;
            else if (lvl_cnt_r != 6'h3f)
                lvl_cnt_r <= lvl_cnt_r + 6'h01;
            if (sclk_rise && !ce)
                addr_sh_r <= {serial_in, addr_sh_r[7:1]};
            if (ce && !ce_q_r)
                bit_cnt_r <= 7'h00;
            else if (sclk_rise && ce)
                bit_cnt_r <= bit_cnt_r + 7'h01;
        end
    end

    property p_dout_low;
        @(posedge clk_sys_i) disable iff (rst_i) dout_oe |-> !dout_o;
    endproperty
    a_dout_low: assert property (p_dout_low)
        else $error("data out driven high");

    property p_pullup;
        @(posedge clk_sys_i) disable iff (rst_i) !dout_oe |-> dout_line;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("released data line not high");

    property p_dout_ce;
        @(posedge clk_sys_i) disable iff (rst_i)
            ce && $past(ce, 4) |-> !dout_oe;
    endproperty
    a_dout_ce: assert property (p_dout_ce)
        else $error("data out pulled low during transfer");

    property p_clk_width;
        @(posedge clk_sys_i) disable iff (rst_i)
            sclk_edge |-> lvl_cnt_r >= 6'h1f;
    endproperty
    a_clk_width: assert property (p_clk_width)
        else $error("shift clock level too short");

    property p_ce_edge;
        @(posedge clk_sys_i) disable iff (rst_i)
            ce != ce_q_r |-> !shift_clk && lvl_cnt_r >= 6'h1f;
    endproperty
    a_ce_edge: assert property (p_ce_edge)
        else $error("chip enable moved too near a clock edge");

    property p_data_stable;
        @(posedge clk_sys_i) disable iff (rst_i)
            shift_clk && sclk_q_r |-> $stable(serial_in);
    endproperty
    a_data_stable: assert property (p_data_stable)
        else $error("data changed while shift clock high");

    property p_addr;
        @(posedge clk_sys_i) disable iff (rst_i) $rose(ce) |-> addr_sh_r == 8'h42;
    endproperty
    a_addr: assert property (p_addr)
        else $error("wrong frame address");

    property p_bits;
        @(posedge clk_sys_i) disable iff (rst_i) $fell(ce) |-> bit_cnt_r == 7'h61;
    endproperty
    a_bits: assert property (p_bits)
        else $error("payload bit count wrong");
endmodule
`default_nettype wire

// ### tb/lcd_serial_control_decoder_tb.sv
// Testbench: controller and display ends joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module lcd_serial_control_decoder_tb;
    import lsd_pkg::*;
    logic clk_sys_i, rst_i, frame_valid_i, frame_ready_o, busy_o, key_req_o;
    lsd_frame_t frame_i;
    logic hw_reset_n_b, b_ce, b_clk, b_si;
    logic [44:0] seg_a, seg_b;
    logic [3:0] pm_a, pm_b;
    logic [5:0] sc_a, sc_b;
    logic [29:0] key_b;
    logic pa_a, pb_a, sl_a, osc_a, pa_b, pb_b, sl_b, osc_b;
    int n_mismatch = 0;
    int num_checks = 0;
    lsd_frame_t exp_q[$];

    lsd_link_if link();
    lsd_link_if link_b();
    // Second link is driven by the bench to send bad frames on purpose
    assign link_b.ce = b_ce;
    assign link_b.shift_clk = b_clk;
    assign link_b.serial_in = b_si;

    lsd_host i_lsd_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .frame_valid_i(frame_valid_i), .frame_ready_o(frame_ready_o),
        .frame_i(frame_i), .busy_o(busy_o), .key_req_o(key_req_o), .link(link));
    lsd_device i_lsd_device (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .hw_reset_n_i(1'b1), .scan_sense_lines_i(5'h00), .seg_o(seg_a),
        .port_mode_o(pm_a), .backplane_phase_a_o(pa_a),
        .backplane_phase_b_o(pb_a), .scan_drive_lines_o(sc_a),
        .key_data_o(), .sleep_o(sl_a), .osc_run_o(osc_a), .link(link));
    lsd_device i_lsd_device_b (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .hw_reset_n_i(hw_reset_n_b), .scan_sense_lines_i(5'h00),
        .seg_o(seg_b), .port_mode_o(pm_b), .backplane_phase_a_o(pa_b),
        .backplane_phase_b_o(pb_b), .scan_drive_lines_o(sc_b),
        .key_data_o(key_b), .sleep_o(sl_b), .osc_run_o(osc_b),
        .link(link_b));
    lsd_link_properties i_lsd_link_properties (.clk_sys_i(clk_sys_i),
        .rst_i(rst_i), .ce(link.ce), .shift_clk(link.shift_clk),
        .serial_in(link.serial_in), .dout_o(link.dout_o),
        .dout_oe(link.dout_oe), .dout_line(link.dout_line));

    task automatic wrap_up();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input bit ok, input string m);
        num_checks++;
        if (!ok) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    // Control fields cycle through every code over successive frames
    function automatic lsd_frame_t mkf(input int k);
        lsd_frame_t f;
        f[89:0] = 90'({$urandom(), $urandom(), $urandom()});
        f[91:90] = 2'(k % 4);
        f[93:92] = 2'((k / 2) % 4);
        f[95:94] = 2'((k + 1) % 4);
        f[96] = k == 4;
        return f;
    endfunction

    task automatic cmp(input lsd_frame_t f, input logic hon,
        input logic [44:0] s, input logic [3:0] pm, input logic [5:0] sc,
        input logic sl, input logic osc, input logic ba, input logic bb);
        int np;
        logic slp;
        logic [44:0] es;
        logic [5:0] esc;
        logic [3:0] epm;
        slp = f[90] | f[91];
        np = f[94] ? (f[95] ? 4 : 3) : (f[95] ? 2 : 0);
        esc = (!slp || (f[90] & f[91])) ? 6'h3f : (f[90] ? 6'h30 : 6'h20);
        for (int n = 0; n < 45; n++)
            es[n] = !slp && !f[96] && hon && f[2 * n + (ba ? 0 : 1)];
        for (int n = 0; n < 4; n++) begin
            epm[n] = n < np;
            if (n < np)
                es[n] = f[2 * n];
        end
        if (slp || !(f[92] | f[93]))
            es[43] = esc[0];
        if (slp || !f[92])
            es[44] = esc[1];
        esc[1:0] = es[44:43];
        chk(s === es, "segment levels");
        chk(pm === epm, "port selection");
        chk(sc === esc, "scan line levels");
        chk(sl === slp && osc === !slp, "sleep state");
        chk(!slp || {ba, bb} === 2'b00, "backplane in sleep");
        chk(slp || !hon || (ba ^ bb) === 1'b1, "backplane phase");
    endtask

    // Valid stays up between frames so it is never lowered and raised at once
    task automatic push(input lsd_frame_t f);
        logic r;
        frame_i = f;
        frame_valid_i = 1'b1;
        do begin
            #1 r = frame_ready_o;
            @(negedge clk_sys_i);
        end while (!r);
    endtask

    task automatic send_b(input logic [7:0] a, input int nb, input lsd_frame_t f);
        for (int i = 0; i < 8 + nb; i++) begin
            if (i == 8)
                b_ce = 1'b1;
            b_si = i < 8 ? a[i] : (i < 105 ? f[i - 8] : i[0]);
            #24 b_clk = 1'b1;
            #24 b_clk = 1'b0;
        end
        #24 b_ce = 1'b0;
        #24 b_si = ~b_si;
        repeat (10) @(negedge clk_sys_i);
    endtask

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        #(90000 * 5);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        @(negedge rst_i);
        forever begin
            @(negedge link.ce);
            repeat (40) @(negedge clk_sys_i);
            if (exp_q.size() > 0)
                cmp(exp_q.pop_front(), 1'b1, seg_a, pm_a, sc_a, sl_a, osc_a, pa_a, pb_a);
        end
    end

    initial begin
        lsd_frame_t f, g, h;
        void'($urandom(73));
        rst_i = 1'b1;
        frame_valid_i = 1'b0;
        frame_i = '0;
        hw_reset_n_b = 1'b1;
        b_ce = 1'b0;
        b_clk = 1'b0;
        b_si = 1'b0;
        repeat (10) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        cmp('0, 1'b1, seg_a, pm_a, sc_a, sl_a, osc_a, pa_a, pb_a);
        for (int k = 0; k < 9; k++) begin
            f = mkf(k);
            exp_q.push_back(f);
            push(f);
        end
        frame_valid_i = 1'b0;
        #1;
        chk(frame_ready_o === 1'b0 && busy_o === 1'b1, "queue not full");
        hw_reset_n_b = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        cmp('0, 1'b0, seg_b, pm_b, sc_b, sl_b, osc_b, pa_b, pb_b);
        chk(key_b === 30'h0 && link_b.dout_line === 1'b1, "keys held");
        g = mkf(8);
        h = mkf(5);
        send_b(8'h42, 97, g);
        hw_reset_n_b = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        cmp(g, 1'b1, seg_b, pm_b, sc_b, sl_b, osc_b, pa_b, pb_b);
        send_b(8'h43, 97, h);
        cmp(g, 1'b1, seg_b, pm_b, sc_b, sl_b, osc_b, pa_b, pb_b);
        send_b(8'h42, 96, h);
        cmp(g, 1'b1, seg_b, pm_b, sc_b, sl_b, osc_b, pa_b, pb_b);
        send_b(8'h42, 100, h);
        cmp(h, 1'b1, seg_b, pm_b, sc_b, sl_b, osc_b, pa_b, pb_b);
        for (int i = 0; i < 70000 && exp_q.size() > 0; i++)
            @(negedge clk_sys_i);
        repeat (50) @(negedge clk_sys_i);
        chk(exp_q.size() == 0 && key_req_o === 1'b0, "frames missing");
        wrap_up();
    end
endmodule
`default_nettype wire
